// ---- pkg/trac_pkg.sv ----
// Package for the test register bank: offsets, field positions, reset values, timing.
// Assumes a single 20 MHz core clock shared by every user of this package.
package trac_pkg;
	// ----------------------------------------
	// Register offsets in test space
	// ----------------------------------------
	localparam logic [7:0] TRAC_OFS_PIN_ACT = 8'h03;
	localparam logic [7:0] TRAC_OFS_COMM_BUF = 8'h04;
	localparam logic [7:0] TRAC_OFS_COMM_RDY = 8'h05;
	localparam logic [7:0] TRAC_OFS_AOBS = 8'h06;
	localparam logic [7:0] TRAC_OFS_DOBS = 8'h07;
	localparam logic [7:0] TRAC_OFS_AINJ = 8'h08;
	localparam logic [7:0] TRAC_OFS_DINJ = 8'h09;
	localparam logic [7:0] TRAC_OFS_NVM = 8'h0d;
	localparam logic [7:0] TRAC_OFS_OWNER = 8'h0e;
	localparam logic [7:0] TRAC_OFS_FLT_A = 8'h14;
	localparam logic [7:0] TRAC_OFS_FLT_B = 8'h15;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int TRAC_BIT_TEST_INPUT_PIN_ACTIVATE = 0;
	localparam int TRAC_BIT_TEST_OUTPUT_NEG_ACTIVATE = 1;
	localparam int TRAC_BIT_TOP_ACT = 2;
	localparam int TRAC_BIT_ERR_CLR = 3;
	localparam int TRAC_BIT_PROG = 3;
	localparam int TRAC_BIT_BYPASS = 4;
	localparam int TRAC_BIT_REFRESH = 5;
	localparam int TRAC_BIT_IF_SEL = 0;
	localparam int TRAC_BIT_HOLD_RST = 1;
	localparam int TRAC_BIT_INVALID_CMD = 1;
	// Writable masks per register
	localparam logic [7:0] TRAC_MSK_PIN_ACT = 8'h0f;
	localparam logic [7:0] TRAC_MSK_AOBS = 8'h3f;
	localparam logic [7:0] TRAC_MSK_DOBS = 8'h1f;
	localparam logic [7:0] TRAC_MSK_AINJ = 8'h3f;
	localparam logic [7:0] TRAC_MSK_DINJ = 8'h0f;
	localparam logic [7:0] TRAC_MSK_NVM = 8'h3f;
	localparam logic [7:0] TRAC_MSK_OWNER = 8'h03;
	localparam logic [7:0] TRAC_MSK_FLT_B = 8'h03;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] TRAC_RST_BYTE = 8'h00;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int TRAC_CLK_HZ = 20000000;
	localparam int TRAC_PROG_TIMEOUT_MS = 15;
	localparam int TRAC_PROG_TIMEOUT_CYC = TRAC_CLK_HZ / 1000 * TRAC_PROG_TIMEOUT_MS;
endpackage

// ---- rtl/trac_prog_timer.sv ----
// Programming request timeout counter.
// Assumes start is a one-cycle pulse and the timeout count fits 20 bits.
`timescale 1ns/1ps
`default_nettype none
module trac_prog_timer #(
	parameter int TIMEOUT_CYC = trac_pkg::TRAC_PROG_TIMEOUT_CYC
)
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic active_in,
	output logic expire_out
);
	import trac_pkg::*;
	// ----------------------------------------
	// Counter
	// ----------------------------------------
	logic [19:0] cnt_r; // Cycles still to run
	logic run_r; // Timer armed
	// Restart on every new request; stop when request drops early
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt_r <= 20'h00000;
			run_r <= 1'b0;
		end
		else if (start_in)
		begin
			cnt_r <= 20'(TIMEOUT_CYC - 1);
			run_r <= 1'b1;
		end
		else if (!active_in)
			run_r <= 1'b0;
		else if (run_r && cnt_r != 20'h00000)
			cnt_r <= cnt_r - 20'h00001;
		else if (run_r)
			run_r <= 1'b0;
	end
	// Fires on the cycle the count is exhausted
	assign expire_out = run_r && active_in && !start_in && (cnt_r == 20'h00000);
endmodule
`default_nettype wire

// ---- rtl/trac_test_regs.sv ----
// Test register bank reached only from the external digital interface.
// Assumes the interface protocol engine presents one-cycle write/read strobes
// synchronous to core_clk_in; read data is registered one cycle later.
//
// Overview of operation
// - Bank reachable only via external interface port
// - After reset interface limited to test space
// - Select bit grants interface all memory
// - Hold-reset bit keeps processor in reset
// - Eight-bit mailbox byte, reset zero
// - Ready bit set on processor load
// - Analog observe code picks output node pair
// - Digital observe code routes signals to pins
// - High observe codes show decimator, interrupt lines
// - Analog inject code picks input node pair
// - Program request self-clears after 15ms unless the bypass bit is set
// - Cache refresh reloads selected bank
// - First fault register flags timing faults
// - Second fault register flags invalid command
`timescale 1ns/1ps
`default_nettype none
module trac_test_regs #(
	parameter int PROG_TIMEOUT_CYC = trac_pkg::TRAC_PROG_TIMEOUT_CYC
)
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// External interface register port
	input wire logic [7:0] if_addr_in,
	input wire logic [7:0] if_wdata_in,
	input wire logic if_wr_in,
	input wire logic if_rd_in,
	output logic [7:0] if_rdata_out,
	// Processor side of the mailbox
	input wire logic cpu_buf_wr_in,
	input wire logic [7:0] cpu_buf_data_in,
	// Processor memory request
	input wire logic cpu_mem_req_in,
	output logic cpu_mem_grant_out,
	// Memory ownership and processor reset
	output logic if_mem_owner_out,
	output logic if_test_only_out,
	output logic cpu_hold_reset_out,
	// Fault events from the single-wire engine
	input wire logic [7:0] flt_a_event_in,
	input wire logic [1:0] flt_b_event_in,
	// Test pin and mux controls
	output logic test_input_pin_activate_out,
	output logic test_output_neg_activate_out,
	output logic test_output_pos_activate_out,
	output logic [5:0] analog_observe_select_out,
	output logic [4:0] digital_observe_select_out,
	output logic [5:0] analog_inject_select_out,
	output logic [3:0] digital_inject_select_out,
	// Digital observe and inject sources and resulting pins
	input wire logic [31:0] dobs_pos_src_in,
	input wire logic [31:0] dobs_neg_src_in,
	output logic test_out_pos_pin_out,
	output logic test_out_neg_pin_out,
	input wire logic [15:0] dinj_src_in,
	output logic test_in_pos_pin_out,
	// Non-volatile bank control
	output logic [2:0] nvm_bank_choice_out,
	output logic host_nvm_program_out,
	output logic nvm_cache_refresh_out
);
	import trac_pkg::*;
	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] pin_act_r; // Test pin activation
	logic [7:0] comm_buf_r; // Mailbox byte
	logic comm_rdy_r; // Mailbox ready
	logic [7:0] aobs_r; // Analog observe select
	logic [7:0] dobs_r; // Digital observe select
	logic [7:0] ainj_r; // Analog inject select
	logic [7:0] dinj_r; // Digital inject select
	logic [7:0] nvm_r; // Non-volatile control
	logic [7:0] owner_r; // Memory owner control
	logic [7:0] flt_a_r; // Fault flags A
	logic [7:0] flt_b_r; // Fault flags B
	logic [7:0] rdata_r; // Registered read data
	logic prog_expire; // Timeout pulse
	logic prog_start; // Request newly set
	// Decoded write strobes
	logic wr_pin, wr_buf, wr_rdy, wr_aobs, wr_dobs, wr_ainj, wr_dinj, wr_nvm, wr_own, wr_fa, wr_fb;
	// The bank has no processor-side register port, only the mailbox load, so it is never in its map
	assign wr_pin = if_wr_in && if_addr_in == TRAC_OFS_PIN_ACT;
	assign wr_buf = if_wr_in && if_addr_in == TRAC_OFS_COMM_BUF;
	assign wr_rdy = if_wr_in && if_addr_in == TRAC_OFS_COMM_RDY;
	assign wr_aobs = if_wr_in && if_addr_in == TRAC_OFS_AOBS;
	assign wr_dobs = if_wr_in && if_addr_in == TRAC_OFS_DOBS;
	assign wr_ainj = if_wr_in && if_addr_in == TRAC_OFS_AINJ;
	assign wr_dinj = if_wr_in && if_addr_in == TRAC_OFS_DINJ;
	assign wr_nvm = if_wr_in && if_addr_in == TRAC_OFS_NVM;
	assign wr_own = if_wr_in && if_addr_in == TRAC_OFS_OWNER;
	assign wr_fa = if_wr_in && if_addr_in == TRAC_OFS_FLT_A;
	assign wr_fb = if_wr_in && if_addr_in == TRAC_OFS_FLT_B;
	// ----------------------------------------
	// Plain control registers
	// ----------------------------------------
	// Reserved bits are masked off so they always read zero
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pin_act_r <= TRAC_RST_BYTE;
			aobs_r <= TRAC_RST_BYTE;
			dobs_r <= TRAC_RST_BYTE;
			ainj_r <= TRAC_RST_BYTE;
			dinj_r <= TRAC_RST_BYTE;
		end
		else
		begin
			if (wr_pin)
				pin_act_r <= if_wdata_in & TRAC_MSK_PIN_ACT;
			if (wr_aobs)
				aobs_r <= if_wdata_in & TRAC_MSK_AOBS;
			if (wr_dobs)
				dobs_r <= if_wdata_in & TRAC_MSK_DOBS;
			if (wr_ainj)
				ainj_r <= if_wdata_in & TRAC_MSK_AINJ;
			if (wr_dinj)
				dinj_r <= if_wdata_in & TRAC_MSK_DINJ;
		end
	end
	// ----------------------------------------
	// Mailbox
	// ----------------------------------------
	// Processor load wins over a host write in the same cycle
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			comm_buf_r <= TRAC_RST_BYTE;
			comm_rdy_r <= 1'b0;
		end
		else
		begin
			if (cpu_buf_wr_in)
				comm_buf_r <= cpu_buf_data_in;
			else if (wr_buf)
				comm_buf_r <= if_wdata_in;
			// Set wins over host clear
			if (cpu_buf_wr_in)
				comm_rdy_r <= 1'b1;
			else if (wr_rdy)
				comm_rdy_r <= if_wdata_in[0];
		end
	end
	// ----------------------------------------
	// Non-volatile control
	// ----------------------------------------
	assign prog_start = wr_nvm && if_wdata_in[TRAC_BIT_PROG] && !nvm_r[TRAC_BIT_PROG];
	trac_prog_timer #(
		.TIMEOUT_CYC(PROG_TIMEOUT_CYC)
	)
	u_prog_timer (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.start_in(prog_start),
		.active_in(nvm_r[TRAC_BIT_PROG]),
		.expire_out(prog_expire)
	);
	// Refresh bit is a self-clearing one-cycle command
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			nvm_r <= TRAC_RST_BYTE;
		else if (wr_nvm)
			nvm_r <= if_wdata_in & TRAC_MSK_NVM;
		else
		begin
			if (prog_expire && !nvm_r[TRAC_BIT_BYPASS])
				nvm_r[TRAC_BIT_PROG] <= 1'b0;
			nvm_r[TRAC_BIT_REFRESH] <= 1'b0;
		end
	end
	// ----------------------------------------
	// Memory ownership
	// ----------------------------------------
	// Hold-reset is sticky: writing zero takes no action
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			owner_r <= TRAC_RST_BYTE;
		else if (wr_own)
		begin
			owner_r[TRAC_BIT_IF_SEL] <= if_wdata_in[TRAC_BIT_IF_SEL];
			if (if_wdata_in[TRAC_BIT_HOLD_RST])
				owner_r[TRAC_BIT_HOLD_RST] <= 1'b1;
		end
	end
	assign if_mem_owner_out = owner_r[TRAC_BIT_IF_SEL];
	assign if_test_only_out = !owner_r[TRAC_BIT_IF_SEL];
	assign cpu_mem_grant_out = cpu_mem_req_in && !owner_r[TRAC_BIT_IF_SEL];
	assign cpu_hold_reset_out = owner_r[TRAC_BIT_HOLD_RST];
	// ----------------------------------------
	// Single-wire fault flags
	// ----------------------------------------
	// New events win over both the clear bit and host writes
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			flt_a_r <= TRAC_RST_BYTE;
			flt_b_r <= TRAC_RST_BYTE;
		end
		else
		begin
			if (pin_act_r[TRAC_BIT_ERR_CLR])
			begin
				flt_a_r <= flt_a_event_in;
				flt_b_r <= {6'h00, flt_b_event_in};
			end
			else
			begin
				flt_a_r <= (wr_fa ? if_wdata_in : flt_a_r) | flt_a_event_in;
				flt_b_r <= ((wr_fb ? if_wdata_in : flt_b_r) & TRAC_MSK_FLT_B) | {6'h00, flt_b_event_in};
			end
		end
	end
	// ----------------------------------------
	// Test multiplexers
	// ----------------------------------------
	assign test_input_pin_activate_out = pin_act_r[TRAC_BIT_TEST_INPUT_PIN_ACTIVATE];
	assign test_output_neg_activate_out = pin_act_r[TRAC_BIT_TEST_OUTPUT_NEG_ACTIVATE];
	assign test_output_pos_activate_out = pin_act_r[TRAC_BIT_TOP_ACT];
	assign analog_observe_select_out = aobs_r[5:0];
	assign digital_observe_select_out = dobs_r[4:0];
	assign analog_inject_select_out = ainj_r[5:0];
	assign digital_inject_select_out = dinj_r[3:0];
	// Code 0 forces the pins low whatever source 0 is; codes 0x10 up carry decimator and interrupt lines
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			test_out_pos_pin_out <= 1'b0;
			test_out_neg_pin_out <= 1'b0;
			test_in_pos_pin_out <= 1'b0;
		end
		else
		begin
			test_out_pos_pin_out <= pin_act_r[TRAC_BIT_TOP_ACT] && dobs_r[4:0] != 5'h00 && dobs_pos_src_in[dobs_r[4:0]];
			test_out_neg_pin_out <= pin_act_r[TRAC_BIT_TEST_OUTPUT_NEG_ACTIVATE] && dobs_r[4:0] != 5'h00 && dobs_neg_src_in[dobs_r[4:0]];
			test_in_pos_pin_out <= dinj_r[3:0] != 4'h0 && dinj_src_in[dinj_r[3:0]];
		end
	end
	assign nvm_bank_choice_out = nvm_r[2:0];
	assign host_nvm_program_out = nvm_r[TRAC_BIT_PROG];
	assign nvm_cache_refresh_out = nvm_r[TRAC_BIT_REFRESH];
	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Unmapped addresses read zero
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rdata_r <= TRAC_RST_BYTE;
		else if (if_rd_in)
		begin
			case (if_addr_in)
				TRAC_OFS_PIN_ACT: rdata_r <= pin_act_r;
				TRAC_OFS_COMM_BUF: rdata_r <= comm_buf_r;
				TRAC_OFS_COMM_RDY: rdata_r <= {7'h00, comm_rdy_r};
				TRAC_OFS_AOBS: rdata_r <= aobs_r;
				TRAC_OFS_DOBS: rdata_r <= dobs_r;
				TRAC_OFS_AINJ: rdata_r <= ainj_r;
				TRAC_OFS_DINJ: rdata_r <= dinj_r;
				TRAC_OFS_NVM: rdata_r <= nvm_r;
				TRAC_OFS_OWNER: rdata_r <= owner_r;
				TRAC_OFS_FLT_A: rdata_r <= flt_a_r;
				TRAC_OFS_FLT_B: rdata_r <= flt_b_r;
				default: rdata_r <= 8'h00;
			endcase
		end
	end
	assign if_rdata_out = rdata_r;
endmodule
`default_nettype wire

// ---- tb/trac_chk.sv ----
// Checker for the test register bank, watching only the top ports.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module trac_chk
	import trac_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] if_addr_in,
	input wire logic [7:0] if_wdata_in,
	input wire logic if_wr_in,
	input wire logic if_rd_in,
	input wire logic [7:0] if_rdata_out,
	input wire logic cpu_mem_req_in,
	input wire logic cpu_mem_grant_out,
	input wire logic if_mem_owner_out,
	input wire logic if_test_only_out,
	input wire logic cpu_hold_reset_out,
	input wire logic test_input_pin_activate_out,
	input wire logic [4:0] digital_observe_select_out,
	input wire logic test_out_pos_pin_out,
	input wire logic nvm_cache_refresh_out
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_grant;
		cpu_mem_grant_out == (cpu_mem_req_in && !if_mem_owner_out);
	endproperty
	property p_test_only;
		if_test_only_out == !if_mem_owner_out;
	endproperty
	property p_owner_set;
		if_wr_in && if_addr_in == TRAC_OFS_OWNER && if_wdata_in[0] |=> if_mem_owner_out;
	endproperty
	property p_hold_set;
		if_wr_in && if_addr_in == TRAC_OFS_OWNER && if_wdata_in[1] |=> cpu_hold_reset_out;
	endproperty
	// Only a reset may release the processor, so once high it stays high
	property p_hold_keep;
		cpu_hold_reset_out |=> cpu_hold_reset_out;
	endproperty
	property p_refresh;
		if_wr_in && if_addr_in == TRAC_OFS_NVM && if_wdata_in[5] |=> nvm_cache_refresh_out;
	endproperty
	property p_pin_act;
		if_wr_in && if_addr_in == TRAC_OFS_PIN_ACT |=> test_input_pin_activate_out == $past(if_wdata_in[0]);
	endproperty
	property p_dobs_zero;
		digital_observe_select_out == 5'h00 |=> !test_out_pos_pin_out;
	endproperty
	property p_unmapped;
		if_rd_in && if_addr_in == 8'h0a |=> if_rdata_out == 8'h00;
	endproperty
	a_grant: assert property (p_grant) else $error("processor grant wrong");
	a_test_only: assert property (p_test_only) else $error("test-only flag wrong");
	a_owner_set: assert property (p_owner_set) else $error("select bit not set");
	a_hold_set: assert property (p_hold_set) else $error("hold-reset not set");
	a_hold_keep: assert property (p_hold_keep) else $error("hold-reset dropped");
	a_refresh: assert property (p_refresh) else $error("no refresh pulse");
	a_pin_act: assert property (p_pin_act) else $error("input pin activation wrong");
	a_dobs_zero: assert property (p_dobs_zero) else $error("observe code zero not low");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	c_owner: cover property (if_mem_owner_out && cpu_mem_req_in);
	c_refresh: cover property (nvm_cache_refresh_out);
	c_hold: cover property (cpu_hold_reset_out);
endmodule
bind trac_test_regs trac_chk trac_chk_inst (.core_clk_in, .rst_n_in, .if_addr_in, .if_wdata_in, .if_wr_in,
	.if_rd_in, .if_rdata_out, .cpu_mem_req_in, .cpu_mem_grant_out, .if_mem_owner_out, .if_test_only_out,
	.cpu_hold_reset_out, .test_input_pin_activate_out, .digital_observe_select_out, .test_out_pos_pin_out,
	.nvm_cache_refresh_out);
`default_nettype wire

// ---- tb/trac_host_model.sv ----
// Host model: drives the register port as the external interface engine would.
// Assumes tasks are called from one bench thread at a time.
`timescale 1ns/1ps
`default_nettype none
module trac_host_model (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	initial
	begin
		addr_out = 8'h0a;
		wdata_out = 8'h5a;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// Stale data is inverted after release so it never looks valid
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		wdata_out = ~d;
	endtask
	// Read data is registered, so it is taken one cycle after the strobe edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		d = rdata_in;
	endtask
	// Processor is held in reset before memory is taken over
	task automatic take_memory;
		wr_reg(8'h0e, 8'h02);
		wr_reg(8'h0e, 8'h03);
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the test register bank.
// Assumes the checker is bound in and the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import trac_pkg::*;
	localparam int TO = 20;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cpu_wr = 1'b0, cpu_req = 1'b0;
	logic [7:0] cpu_d = 8'h00, flt_a = 8'h00, a, d, q;
	logic [1:0] flt_b = 2'b00;
	logic [31:0] dpos = 32'h0, dneg = 32'h0;
	logic [15:0] dinj = 16'h0;
	int n_fail = 0, n_tests = 0;
	logic [7:0] ofs [9] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h14, 8'h15};
	wire logic [7:0] addr, wdata, rdata;
	wire logic wr, rd, grant, owner, tonly, hold, test_in_pos_pin, test_out_neg_pin, top, pin_p, pin_n, pin_i, prog, refr;
	wire logic [5:0] aobs, ainj;
	wire logic [4:0] dobs;
	wire logic [3:0] dsel;
	wire logic [2:0] bank;
	always #25 core_clk_in = ~core_clk_in;
	trac_host_model trac_host_model_inst (.clk_in(core_clk_in), .rdata_in(rdata), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	trac_test_regs #(.PROG_TIMEOUT_CYC(TO)) trac_test_regs_inst (.core_clk_in, .rst_n_in, .if_addr_in(addr),
		.if_wdata_in(wdata), .if_wr_in(wr), .if_rd_in(rd), .if_rdata_out(rdata), .cpu_buf_wr_in(cpu_wr),
		.cpu_buf_data_in(cpu_d), .cpu_mem_req_in(cpu_req), .cpu_mem_grant_out(grant), .if_mem_owner_out(owner),
		.if_test_only_out(tonly), .cpu_hold_reset_out(hold), .flt_a_event_in(flt_a), .flt_b_event_in(flt_b),
		.test_input_pin_activate_out(test_in_pos_pin), .test_output_neg_activate_out(test_out_neg_pin), .test_output_pos_activate_out(top),
		.analog_observe_select_out(aobs), .digital_observe_select_out(dobs), .analog_inject_select_out(ainj),
		.digital_inject_select_out(dsel), .dobs_pos_src_in(dpos), .dobs_neg_src_in(dneg), .test_out_pos_pin_out(pin_p),
		.test_out_neg_pin_out(pin_n), .dinj_src_in(dinj), .test_in_pos_pin_out(pin_i), .nvm_bank_choice_out(bank),
		.host_nvm_program_out(prog), .nvm_cache_refresh_out(refr));
	// Writable bits of each register; reserved bits read back as zero
	function automatic logic [7:0] msk(input logic [7:0] x);
		case (x)
			8'h03: return TRAC_MSK_PIN_ACT;
			8'h05: return 8'h01;
			8'h06: return TRAC_MSK_AOBS;
			8'h07: return TRAC_MSK_DOBS;
			8'h08: return TRAC_MSK_AINJ;
			8'h09: return TRAC_MSK_DINJ;
			8'h15: return TRAC_MSK_FLT_B;
			default: return 8'hff;
		endcase
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			$display("ERROR %0t got %h expected %h", $time, g, e);
			n_fail++;
		end
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d errors %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog sized well above the expected run length
	initial
	begin
		repeat (20000) @(posedge core_clk_in);
		n_fail++;
		tally_and_finish();
	end
	initial
	begin
		void'($urandom(32'ha2be));
		repeat (20) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		foreach (ofs[i])
		begin
			trac_host_model_inst.rd_reg(ofs[i], q);
			chk(q, 8'h00);
		end
		chk({5'h0, owner, tonly, hold}, 8'h02);
		// Random write and read-back; clear bit kept low so fault flags hold values
		repeat (40)
		begin
			a = ofs[$urandom_range(8, 0)];
			d = 8'($urandom) & ((a == 8'h03) ? 8'hf7 : 8'hff);
			trac_host_model_inst.wr_reg(a, d);
			trac_host_model_inst.rd_reg(a, q);
			chk(q, d & msk(a));
		end
		trac_host_model_inst.wr_reg(8'h0a, 8'hff);
		trac_host_model_inst.rd_reg(8'h0a, q);
		chk(q, 8'h00);
		// Digital observe codes 0 to 20 and lower codes of the other muxes, with fresh random sources each pass
		trac_host_model_inst.wr_reg(8'h03, 8'h07);
		chk({5'h0, top, test_out_neg_pin, test_in_pos_pin}, 8'h07);
		for (int c = 0; c < 21; c++)
		begin
			dpos = $urandom;
			dneg = $urandom;
			dinj = 16'($urandom);
			trac_host_model_inst.wr_reg(8'h06, 8'(c % 18));
			trac_host_model_inst.wr_reg(8'h07, 8'(c));
			trac_host_model_inst.wr_reg(8'h08, 8'(c % 16));
			trac_host_model_inst.wr_reg(8'h09, 8'(c % 16));
			@(negedge core_clk_in);
			chk({2'h0, aobs}, 8'(c % 18));
			chk({2'h0, ainj}, 8'(c % 16));
			chk({3'h0, dobs}, 8'(c));
			chk({4'h0, dsel}, 8'(c % 16));
			chk({7'h0, pin_p}, (c == 0) ? 8'h00 : {7'h0, dpos[c]});
			chk({7'h0, pin_n}, (c == 0) ? 8'h00 : {7'h0, dneg[c]});
			chk({7'h0, pin_i}, (c % 16 == 0) ? 8'h00 : {7'h0, dinj[c % 16]});
		end
		dpos = 32'hffffffff;
		trac_host_model_inst.wr_reg(8'h03, 8'h00);
		repeat (2) @(negedge core_clk_in);
		chk({4'h0, top, test_out_neg_pin, test_in_pos_pin, pin_p}, 8'h00);
		// Random writes may have left the ready bit set, so clear it first
		trac_host_model_inst.wr_reg(8'h05, 8'h00);
		trac_host_model_inst.rd_reg(8'h05, q);
		chk(q, 8'h00);
		cpu_d = 8'($urandom);
		cpu_wr = 1'b1;
		@(negedge core_clk_in);
		cpu_wr = 1'b0;
		trac_host_model_inst.rd_reg(8'h05, q);
		chk(q, 8'h01);
		trac_host_model_inst.rd_reg(8'h04, q);
		chk(q, cpu_d);
		// Start the fault flags from zero so only the events below can set them
		trac_host_model_inst.wr_reg(8'h14, 8'h00);
		trac_host_model_inst.wr_reg(8'h15, 8'h00);
		flt_a = 8'h81;
		flt_b = 2'b10;
		@(negedge core_clk_in);
		flt_a = 8'h00;
		flt_b = 2'b00;
		trac_host_model_inst.rd_reg(8'h14, q);
		chk(q, 8'h81);
		trac_host_model_inst.rd_reg(8'h15, q);
		chk(q, 8'h02);
		trac_host_model_inst.wr_reg(8'h03, 8'h08);
		trac_host_model_inst.wr_reg(8'h03, 8'h00);
		trac_host_model_inst.rd_reg(8'h14, q);
		chk(q, 8'h00);
		trac_host_model_inst.rd_reg(8'h15, q);
		chk(q, 8'h00);
		cpu_req = 1'b1;
		trac_host_model_inst.take_memory();
		chk({5'h0, owner, grant, hold}, 8'h05);
		chk({7'h0, tonly}, 8'h00);
		trac_host_model_inst.wr_reg(8'h0e, 8'h00);
		chk({5'h0, owner, grant, hold}, 8'h03);
		trac_host_model_inst.wr_reg(8'h0d, 8'h08);
		chk({7'h0, prog}, 8'h01);
		// Request must still stand one cycle before the count runs out
		repeat (TO - 1) @(negedge core_clk_in);
		chk({7'h0, prog}, 8'h01);
		@(negedge core_clk_in);
		chk({7'h0, prog}, 8'h00);
		trac_host_model_inst.wr_reg(8'h0d, 8'h18);
		repeat (TO + 5) @(negedge core_clk_in);
		chk({7'h0, prog}, 8'h01);
		trac_host_model_inst.wr_reg(8'h0d, 8'h25);
		chk({5'h0, bank}, 8'h05);
		chk({7'h0, refr}, 8'h01);
		@(negedge core_clk_in);
		chk({7'h0, refr}, 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
